// File: shared/sbl_consts.svh
// Constants for the serial block link error handler
// Function
// - Matching check byte and clean block: answer DLE
// - Bad block: answer NAK, wait block time
// - Abort on attempts exhausted or wait expiry
// - Start answered by start means conflict
// - Lower priority yields, answers DLE, receives
// - Higher priority keeps waiting, then sends
// - Yielded send retried afterwards with fresh start
// - Both stations need different priority settings
// - Retry failed blocks up to attempt limit
// - Abort records first error, returns idle
// - Line break flagged, no repetition started except setup start repeated in ACKW
// - Line break flag clears when line returns
// - One fixed code per character error
// - Character errors reported only after retries
// - Damaged character while idle reported at once
// - Check byte XORs data, doubled escapes twice
// - Doubled escape stored once
// - Character timeout: NAK, error, no repetition
`ifndef SBL_CONSTS_SVH
`define SBL_CONSTS_SVH
`define SBL_STX 8'h02
`define SBL_ETX 8'h03
`define SBL_DLE 8'h10
`define SBL_NAK 8'h15
`define SBL_CLK_HZ 32'h0262_5a00
`define SBL_BLK_WAIT_S 32'h4
`define SBL_ACK_DLY_RST 32'h0000_1f40
`define SBL_CHR_DLY_RST 32'h0000_0fa0
`define SBL_MAXA_RST 4'h6
`define SBL_REG_CTRL 4'h0
`define SBL_REG_ACKD 4'h1
`define SBL_REG_CHRD 4'h2
`define SBL_REG_BLKW 4'h3
`define SBL_REG_STAT 4'h4
`define SBL_CTRL_PRIO 0
`define SBL_CTRL_ATT_LO 4
`define SBL_CTRL_ATT_HI 7
`define SBL_STAT_BRK 8
`define SBL_STAT_NEW 9
`define SBL_ERR_LOST 8'h01
`define SBL_ERR_FRAME 8'h02
`define SBL_ERR_PARITY 8'h03
`define SBL_ERR_BCC 8'h04
`define SBL_ERR_CHR_TMO 8'h05
`define SBL_ERR_SETUP 8'h06
`define SBL_ERR_CTRL 8'h07
`define SBL_RESP_OKAY 2'h0
`define SBL_RESP_SLVERR 2'h2
`endif

// File: shared/sbl_pkg.sv
// Types of the serial block link error handler
`default_nettype none
package sbl_pkg;
	typedef enum logic [2:0] {IDLE, ACKW, RDATA, RDLE, RBCC, BWAIT} sbl_state_type;
	typedef struct packed {
		sbl_state_type st;
		logic [31:0] tmr;
		logic [7:0] bcc;
		logic [3:0] att;
		logic [7:0] err1;
		logic [7:0] ecur;
		logic retry;
		logic txv;
		logic [7:0] txd;
		logic ov;
		logic [7:0] od;
		logic grant;
		logic [7:0] code;
		logic cnew;
		logic brk;
		logic prio;
		logic [3:0] maxa;
		logic [31:0] ackd;
		logic [31:0] chrd;
		logic [31:0] blkw;
		logic awr;
		logic wr;
		logic aw_h;
		logic [5:0] aw_a;
		logic w_h;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bv;
		logic [1:0] br;
		logic arr;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} sbl_regs_type;
endpackage
`default_nettype wire

// File: logic/sbl_link.sv
// Block link receive procedure with conflict and error handling
`timescale 1ns/100ps
`default_nettype none
`include "sbl_consts.svh"
module sbl_link #(
	parameter logic [31:0] BLK_WAIT_CYC = `SBL_BLK_WAIT_S * `SBL_CLK_HZ
)(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic [2:0] rx_err_i,
	input wire logic line_break_i,
	input wire logic send_req_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic rcv_valid_o,
	output logic [7:0] rcv_data_o,
	output logic send_grant_o,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [5:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [5:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o
);

sbl_pkg::sbl_regs_type q;
sbl_pkg::sbl_regs_type d;
logic tmo;
logic fail;
logic [7:0] rxc;
logic [7:0] enew;
logic [31:0] wm;
logic [31:0] cur;

// Fixed priority keeps one code per character fault
function automatic logic [7:0] map_err(input logic [2:0] e);
	logic [7:0] c;
	c = 8'h00;
	if (e[0])
		c = `SBL_ERR_LOST;
	else if (e[1])
		c = `SBL_ERR_FRAME;
	else if (e[2])
		c = `SBL_ERR_PARITY;
	return c;
endfunction

////////////////////////////////////////////////////////////////
always_comb
begin
	d = q;
	fail = 1'b0;
	enew = 8'h00;
	cur = 32'h0;
	d.grant = 1'b0;
	d.ov = 1'b0;
	wm = {{8{q.w_s[3]}}, {8{q.w_s[2]}}, {8{q.w_s[1]}}, {8{q.w_s[0]}}};
	rxc = map_err(rx_err_i);
	d.brk = line_break_i;
	tmo = (q.tmr == 32'h0);
	if (!tmo)
		d.tmr = q.tmr - 32'h1;
	if (q.txv && tx_ready_i)
		d.txv = 1'b0;

	// Bus slave first so a hardware set below wins over a clear
	if (s_axi_awvalid_i && q.awr)
	begin
		d.aw_h = 1'b1;
		d.aw_a = s_axi_awaddr_i;
	end
	if (s_axi_wvalid_i && q.wr)
	begin
		d.w_h = 1'b1;
		d.w_d = s_axi_wdata_i;
		d.w_s = s_axi_wstrb_i;
	end
	if (q.aw_h && q.w_h && !q.bv)
	begin
		d.aw_h = 1'b0;
		d.w_h = 1'b0;
		d.bv = 1'b1;
		d.br = `SBL_RESP_OKAY;
		case (q.aw_a[5:2])
			`SBL_REG_CTRL:
			begin
				cur = {24'h0, q.maxa, 3'h0, q.prio};
				cur = (cur & ~wm) | (q.w_d & wm);
				d.prio = cur[`SBL_CTRL_PRIO];
				d.maxa = cur[`SBL_CTRL_ATT_HI:`SBL_CTRL_ATT_LO];
			end
			`SBL_REG_ACKD:
				d.ackd = (q.ackd & ~wm) | (q.w_d & wm);
			`SBL_REG_CHRD:
				d.chrd = (q.chrd & ~wm) | (q.w_d & wm);
			`SBL_REG_BLKW:
				d.blkw = (q.blkw & ~wm) | (q.w_d & wm);
			`SBL_REG_STAT:
			begin
				if (q.w_s[1] && q.w_d[`SBL_STAT_NEW])
					d.cnew = 1'b0;
			end
			default:
				d.br = `SBL_RESP_SLVERR;
		endcase
	end
	if (q.bv && s_axi_bready_i)
		d.bv = 1'b0;
	d.awr = !d.aw_h;
	d.wr = !d.w_h;
	if (s_axi_arvalid_i && q.arr)
	begin
		d.arr = 1'b0;
		d.rv = 1'b1;
		d.rr = `SBL_RESP_OKAY;
		case (s_axi_araddr_i[5:2])
			`SBL_REG_CTRL:
				d.rd = {24'h0, q.maxa, 3'h0, q.prio};
			`SBL_REG_ACKD:
				d.rd = q.ackd;
			`SBL_REG_CHRD:
				d.rd = q.chrd;
			`SBL_REG_BLKW:
				d.rd = q.blkw;
			`SBL_REG_STAT:
				d.rd = {13'h0, q.st, 6'h0, q.cnew, q.brk, q.code};
			default:
			begin
				d.rd = 32'h0;
				d.rr = `SBL_RESP_SLVERR;
			end
		endcase
	end
	if (q.rv && s_axi_rready_i)
	begin
		d.rv = 1'b0;
		d.arr = 1'b1;
	end

	// Procedure steps only while no reply is in flight; a character
	// arriving then is dropped, as the peer waits for our answer.
	if (!q.txv)
	begin
		case (q.st)
			sbl_pkg::IDLE:
			begin
				if (rx_valid_i && rx_err_i != 3'h0)
				begin
					d.code = rxc;
					d.cnew = 1'b1;
				end
				else if (rx_valid_i && rx_data_i == `SBL_STX)
				begin
					d.txv = 1'b1;
					d.txd = `SBL_DLE;
					d.st = sbl_pkg::RDATA;
					d.att = 4'h1;
					d.bcc = 8'h00;
					d.err1 = 8'h00;
					d.ecur = 8'h00;
					d.tmr = q.chrd;
				end
				else if (rx_valid_i && rx_data_i != `SBL_NAK)
				begin
					d.txv = 1'b1;
					d.txd = `SBL_NAK;
					d.code = `SBL_ERR_CTRL;
					d.cnew = 1'b1;
				end
				else if ((send_req_i || q.retry) && !q.brk)
				begin
					d.txv = 1'b1;
					d.txd = `SBL_STX;
					d.st = sbl_pkg::ACKW;
					d.att = 4'h1;
					d.tmr = q.ackd;
				end
			end
			sbl_pkg::ACKW:
			begin
				if (rx_valid_i && rx_err_i == 3'h0 && rx_data_i == `SBL_DLE)
				begin
					d.grant = 1'b1;
					d.retry = 1'b0;
					d.st = sbl_pkg::IDLE;
				end
				else if (rx_valid_i && rx_err_i == 3'h0 && rx_data_i == `SBL_STX)
				begin
					// Equal high settings on both ends wait here until the attempts run out
					if (!q.prio)
					begin
						d.retry = 1'b1;
						d.txv = 1'b1;
						d.txd = `SBL_DLE;
						d.st = sbl_pkg::RDATA;
						d.att = 4'h1;
						d.bcc = 8'h00;
						d.err1 = 8'h00;
						d.ecur = 8'h00;
						d.tmr = q.chrd;
					end
				end
				else if (rx_valid_i || tmo)
					fail = 1'b1;
				if (fail && q.att >= q.maxa)
				begin
					d.txv = 1'b1;
					d.txd = `SBL_NAK;
					d.code = `SBL_ERR_SETUP;
					d.cnew = 1'b1;
					d.retry = 1'b0;
					d.st = sbl_pkg::IDLE;
				end
				else if (fail)
				begin
					d.txv = 1'b1;
					d.txd = `SBL_STX;
					d.att = q.att + 4'h1;
					d.tmr = q.ackd;
				end
			end
			sbl_pkg::RDATA, sbl_pkg::RDLE, sbl_pkg::RBCC:
			begin
				if (q.brk)
					d.st = sbl_pkg::IDLE;
				else if (rx_valid_i)
				begin
					d.tmr = q.chrd;
					d.bcc = q.bcc ^ rx_data_i;
					if (rxc != 8'h00 && q.ecur == 8'h00)
						d.ecur = rxc;
					if (q.st == sbl_pkg::RDATA)
					begin
						if (rx_data_i == `SBL_DLE)
							d.st = sbl_pkg::RDLE;
						else
						begin
							d.ov = 1'b1;
							d.od = rx_data_i;
						end
					end
					else if (q.st == sbl_pkg::RDLE)
					begin
						d.st = sbl_pkg::RDATA;
						if (rx_data_i == `SBL_DLE)
						begin
							d.ov = 1'b1;
							d.od = rx_data_i;
						end
						else if (rx_data_i == `SBL_ETX)
							d.st = sbl_pkg::RBCC;
						else if (d.ecur == 8'h00)
							d.ecur = `SBL_ERR_CTRL;
					end
					else
					begin
						d.bcc = q.bcc;
						d.txv = 1'b1;
						if (rx_data_i == q.bcc && q.ecur == 8'h00 && rxc == 8'h00)
						begin
							d.txd = `SBL_DLE;
							d.st = sbl_pkg::IDLE;
						end
						else
						begin
							d.txd = `SBL_NAK;
							enew = q.ecur;
							if (enew == 8'h00)
								enew = (rxc != 8'h00) ? rxc : `SBL_ERR_BCC;
							if (q.err1 == 8'h00)
								d.err1 = enew;
							// A different fault on a retry ends the block
							if (q.att >= q.maxa || (q.err1 != 8'h00 && enew != q.err1))
							begin
								d.code = d.err1;
								d.cnew = 1'b1;
								d.st = sbl_pkg::IDLE;
							end
							else
							begin
								d.att = q.att + 4'h1;
								d.tmr = q.blkw;
								d.st = sbl_pkg::BWAIT;
							end
						end
					end
				end
				else if (tmo)
				begin
					d.txv = 1'b1;
					d.txd = `SBL_NAK;
					d.code = `SBL_ERR_CHR_TMO;
					d.cnew = 1'b1;
					d.st = sbl_pkg::IDLE;
				end
			end
			sbl_pkg::BWAIT:
			begin
				if (q.brk)
					d.st = sbl_pkg::IDLE;
				else if (rx_valid_i && rx_err_i == 3'h0 && rx_data_i == `SBL_STX)
				begin
					d.txv = 1'b1;
					d.txd = `SBL_DLE;
					d.st = sbl_pkg::RDATA;
					d.bcc = 8'h00;
					d.ecur = 8'h00;
					d.tmr = q.chrd;
				end
				else if (tmo)
				begin
					d.code = q.err1;
					d.cnew = 1'b1;
					d.st = sbl_pkg::IDLE;
				end
			end
			default:
				d.st = sbl_pkg::IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////
always_ff @(posedge mclk_i)
begin
	if (rst_i)
	begin
		q <= '0;
		q.maxa <= `SBL_MAXA_RST;
		q.ackd <= `SBL_ACK_DLY_RST;
		q.chrd <= `SBL_CHR_DLY_RST;
		q.blkw <= BLK_WAIT_CYC;
		q.awr <= 1'b1;
		q.wr <= 1'b1;
		q.arr <= 1'b1;
	end
	else if (ce_i)
		q <= d;
end

assign tx_valid_o = q.txv;
assign tx_data_o = q.txd;
assign rcv_valid_o = q.ov;
assign rcv_data_o = q.od;
assign send_grant_o = q.grant;
assign s_axi_awready_o = q.awr;
assign s_axi_wready_o = q.wr;
assign s_axi_bvalid_o = q.bv;
assign s_axi_bresp_o = q.br;
assign s_axi_arready_o = q.arr;
assign s_axi_rvalid_o = q.rv;
assign s_axi_rdata_o = q.rd;
assign s_axi_rresp_o = q.rr;

////////////////////////////////////////////////////////////////
default clocking cb @(posedge mclk_i);
endclocking
default disable iff (rst_i);

logic step;
assign step = ce_i && !q.txv && rx_valid_i;

chk_bcc_good_ack: assert property (
	step && q.st == sbl_pkg::RBCC && rx_data_i == q.bcc && q.ecur == 8'h00 && !q.brk
	&& rx_err_i == 3'h0 |=> tx_valid_o && tx_data_o == `SBL_DLE && q.st == sbl_pkg::IDLE)
	else $error("good block not acknowledged");
chk_bcc_bad_nak: assert property (
	step && q.st == sbl_pkg::RBCC && rx_data_i != q.bcc && !q.brk
	|=> tx_data_o == `SBL_NAK)
	else $error("bad block not refused");
chk_blk_wait_end: assert property (
	ce_i && q.st == sbl_pkg::BWAIT && !q.brk && tmo && !rx_valid_i
	|=> q.st == sbl_pkg::IDLE && q.cnew)
	else $error("block wait expiry not aborted");
chk_low_yields: assert property (
	step && q.st == sbl_pkg::ACKW && rx_data_i == `SBL_STX && rx_err_i == 3'h0 && !q.prio
	|=> tx_data_o == `SBL_DLE && q.st == sbl_pkg::RDATA && q.retry)
	else $error("low priority did not yield");
chk_high_holds: assert property (
	step && q.st == sbl_pkg::ACKW && rx_data_i == `SBL_STX && rx_err_i == 3'h0 && q.prio
	|=> q.st == sbl_pkg::ACKW && !tx_valid_o)
	else $error("high priority left send");
chk_break_idle: assert property (
	ce_i && !q.txv && q.brk && q.st != sbl_pkg::IDLE && q.st != sbl_pkg::ACKW
	|=> q.st == sbl_pkg::IDLE ##1 (q.st == sbl_pkg::IDLE || $past(rx_valid_i)))
	else $error("repetition after line break");
chk_idle_damage: assert property (
	step && q.st == sbl_pkg::IDLE && rx_err_i != 3'h0
	|=> q.cnew && q.code == ($past(rx_err_i[0]) ? `SBL_ERR_LOST : $past(rx_err_i[1])
	? `SBL_ERR_FRAME : `SBL_ERR_PARITY))
	else $error("idle damage not reported");
chk_esc_once: assert property (
	step && q.st == sbl_pkg::RDLE && !q.brk && rx_data_i == `SBL_DLE
	|=> rcv_valid_o && rcv_data_o == `SBL_DLE ##1 !rcv_valid_o || $past(rx_valid_i))
	else $error("doubled escape mishandled");
chk_chr_timeout: assert property (
	ce_i && !q.txv && q.st == sbl_pkg::RDATA && !q.brk && tmo && !rx_valid_i
	|=> tx_data_o == `SBL_NAK && q.code == `SBL_ERR_CHR_TMO && q.st == sbl_pkg::IDLE)
	else $error("character timeout not handled");
chk_err_deferred: assert property (
	step && q.st == sbl_pkg::RDATA && rx_err_i != 3'h0 |=> $stable(q.code))
	else $error("character error reported early");

cov_conflict: cover property (q.st == sbl_pkg::ACKW ##1 q.st == sbl_pkg::RDATA);
cov_retry: cover property (q.st == sbl_pkg::BWAIT ##[1:1000] q.st == sbl_pkg::RDATA);
cov_good: cover property (q.st == sbl_pkg::RBCC ##1 tx_data_o == `SBL_DLE);

endmodule
`default_nettype wire

// File: test/sbl_peer.sv
// Peer controller model on the character link
`timescale 1ns/100ps
`default_nettype none
`include "sbl_consts.svh"
module sbl_peer (
	input wire logic mclk_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic [2:0] rx_err_o
);
	logic [7:0] got[$];
	initial
	begin
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		rx_err_o = 3'h0;
	end
	// Slow taker: ready every other cycle, so the device must hold its character
	always @(posedge mclk_i)
	begin
		tx_ready_o <= tx_valid_i && !tx_ready_o;
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_data_i);
	end
	////////////////////////////////////////////////////////////
	// Sent only while the device has nothing pending, else it would be dropped
	task automatic put(input logic [7:0] d, input logic [2:0] e);
		do
			@(negedge mclk_i);
		while (tx_valid_i);
		@(posedge mclk_i);
		rx_valid_o <= 1'b1;
		rx_data_o <= d;
		rx_err_o <= e;
		@(posedge mclk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~d;
		rx_err_o <= 3'h0;
	endtask
	// Two data bytes, end pair and check byte; flip spoils the check byte
	task automatic frame(input logic [7:0] d0, input logic [7:0] d1, input logic [2:0] e,
		input logic flip);
		logic [7:0] bcc;
		bcc = d0 ^ d1 ^ {7'h00, flip} ^ `SBL_DLE ^ `SBL_ETX;
		put(d0, e);
		put(d1, 3'h0);
		if (d1 == `SBL_DLE)
		begin
			put(d1, 3'h0);
			bcc = bcc ^ d1;
		end
		put(`SBL_DLE, 3'h0);
		put(`SBL_ETX, 3'h0);
		put(bcc, 3'h0);
	endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the block link procedure
`timescale 1ns/100ps
`default_nettype none
`include "sbl_consts.svh"
module tb_top;
	localparam int BW = 200;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic line_break_i = 1'b0;
	logic send_req_i = 1'b0;
	logic rx_valid_i, tx_ready_i, tx_valid_o, rcv_valid_o, send_grant_o;
	logic [7:0] rx_data_i, tx_data_o, rcv_data_o;
	logic [2:0] rx_err_i;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic [5:0] s_axi_awaddr_i = 6'h00, s_axi_araddr_i = 6'h00;
	logic [31:0] s_axi_wdata_i = 32'h0000_0000;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o, prev;
	logic [7:0] rcvd[$];
	int fails = 0, checks_done = 0, grants = 0;

	always #12.5 mclk_i = ~mclk_i;

	sbl_link #(.BLK_WAIT_CYC(32'h0000_00c8)) dut (.mclk_i, .rst_i, .ce_i, .rx_valid_i, .rx_data_i,
		.rx_err_i, .line_break_i, .send_req_i, .tx_ready_i, .tx_valid_o, .tx_data_o, .rcv_valid_o,
		.rcv_data_o, .send_grant_o, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
		.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o,
		.s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i,
		.s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o);
	sbl_peer peer (.mclk_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
		.tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
		.rx_err_o(rx_err_i));

	always @(posedge mclk_i)
	begin
		if (rcv_valid_o === 1'b1)
			rcvd.push_back(rcv_data_o);
		if (send_grant_o === 1'b1)
			grants++;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Unmapped offsets answer with an error response
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		s_axi_awvalid_i <= 1'b1;
		s_axi_awaddr_i <= a;
		s_axi_wvalid_i <= 1'b1;
		s_axi_wdata_i <= d;
		s_axi_bready_i <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			n++;
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
		end
		while (s_axi_bvalid_o !== 1'b1 && n < 100);
		s_axi_bready_i <= 1'b0;
		chk({s_axi_bvalid_o, s_axi_bresp_o}, {1'b1, (a > 6'h10) ? `SBL_RESP_SLVERR : `SBL_RESP_OKAY});
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
		int n;
		n = 0;
		@(posedge mclk_i);
		s_axi_arvalid_i <= 1'b1;
		s_axi_araddr_i <= a;
		s_axi_rready_i <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			n++;
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
		end
		while (s_axi_rvalid_o !== 1'b1 && n < 100);
		s_axi_rready_i <= 1'b0;
		chk({s_axi_rvalid_o, s_axi_rresp_o, s_axi_rdata_o & m},
			{1'b1, (a > 6'h10) ? `SBL_RESP_SLVERR : `SBL_RESP_OKAY, e});
	endtask
	task automatic exp_tx(input logic [7:0] e);
		for (int n = 0; n < 400 && peer.got.size() == 0; n++)
			@(posedge mclk_i);
		chk((peer.got.size() > 0) ? peer.got.pop_front() : 9'h100, e);
	endtask
	task automatic quiet(input int c);
		repeat (c) @(posedge mclk_i);
		chk(peer.got.size(), 0);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (BW * 100) @(posedge mclk_i);
		fails++;
		complete_run();
	end
	initial
	begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(6'h00, 32'h0000_0060, 32'h0000_00f1);
		rd(6'h04, `SBL_ACK_DLY_RST);
		rd(6'h08, `SBL_CHR_DLY_RST);
		rd(6'h0c, 32'h0000_00c8);
		rd(6'h10, 32'h0000_0000, 32'h0007_03ff);
		rd(6'h14, 32'h0000_0000);
		wr(6'h14, 32'hffff_ffff);
		wr(6'h04, 32'h0000_003c);
		wr(6'h08, 32'h0000_0028);
		wr(6'h00, 32'h0000_0020);
		rd(6'h00, 32'h0000_0020, 32'h0000_00f1);
		// Clean block with a doubled escape inside
		peer.put(`SBL_STX, 3'h0);
		exp_tx(`SBL_DLE);
		peer.frame(8'h41, `SBL_DLE, 3'h0, 1'b0);
		exp_tx(`SBL_DLE);
		chk(rcvd.size(), 2);
		chk(rcvd[0], 8'h41);
		chk(rcvd[1], `SBL_DLE);
		// Lost, framing, parity, check byte: framing and check byte exhaust attempts, lost and parity time out
		prev = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
		begin
			peer.put(`SBL_STX, 3'h0);
			exp_tx(`SBL_DLE);
			peer.frame(8'h41, 8'h42, (i < 3) ? 3'h1 << i : 3'h0, i == 3);
			exp_tx(`SBL_NAK);
			rd(6'h10, prev, 32'h0000_00ff);
			if (i % 2)
			begin
				peer.put(`SBL_STX, 3'h0);
				exp_tx(`SBL_DLE);
				peer.frame(8'h41, 8'h42, (i < 3) ? 3'h1 << i : 3'h0, i == 3);
				exp_tx(`SBL_NAK);
			end
			else
				repeat (BW + 20) @(posedge mclk_i);
			rd(6'h10, 32'h0000_0200 | (i + 1), 32'h0007_03ff);
			wr(6'h10, 32'h0000_0200);
			prev = i + 1;
		end
		peer.put(8'h41, 3'h4);
		rd(6'h10, 32'h0000_0203, 32'h0007_03ff);
		wr(6'h10, 32'h0000_0200);
		// Line break in mid-block: flagged, then silence
		peer.put(`SBL_STX, 3'h0);
		exp_tx(`SBL_DLE);
		peer.put(8'h41, 3'h0);
		line_break_i <= 1'b1;
		// One edge more so the state field has fallen back to idle
		@(posedge mclk_i);
		rd(6'h10, 32'h0000_0103, 32'h0007_03ff);
		quiet(80);
		line_break_i <= 1'b0;
		rd(6'h10, 32'h0000_0000, 32'h0000_0100);
		// Character gap too long; the enable freezes the timer for a while first
		peer.put(`SBL_STX, 3'h0);
		exp_tx(`SBL_DLE);
		peer.put(8'h41, 3'h0);
		ce_i <= 1'b0;
		quiet(60);
		ce_i <= 1'b1;
		exp_tx(`SBL_NAK);
		rd(6'h10, 32'h0000_0205, 32'h0007_03ff);
		wr(6'h10, 32'h0000_0200);
		// Start conflict, low priority yields and retries
		send_req_i <= 1'b1;
		exp_tx(`SBL_STX);
		peer.put(`SBL_STX, 3'h0);
		exp_tx(`SBL_DLE);
		peer.frame(8'h43, 8'h44, 3'h0, 1'b0);
		exp_tx(`SBL_DLE);
		chk(grants, 0);
		exp_tx(`SBL_STX);
		send_req_i <= 1'b0;
		peer.put(`SBL_DLE, 3'h0);
		for (int n = 0; n < 20 && grants < 1; n++)
			@(posedge mclk_i);
		chk(grants, 1);
		// Start conflict, high priority holds on
		wr(6'h00, 32'h0000_0021);
		send_req_i <= 1'b1;
		exp_tx(`SBL_STX);
		send_req_i <= 1'b0;
		peer.put(`SBL_STX, 3'h0);
		quiet(20);
		peer.put(`SBL_DLE, 3'h0);
		for (int n = 0; n < 20 && grants < 2; n++)
			@(posedge mclk_i);
		chk(grants, 2);
		// Unanswered setup runs out of attempts
		send_req_i <= 1'b1;
		exp_tx(`SBL_STX);
		send_req_i <= 1'b0;
		exp_tx(`SBL_STX);
		exp_tx(`SBL_NAK);
		rd(6'h10, 32'h0000_0206, 32'h0007_03ff);
		// Refused setup is repeated; a stray control while idle is refused at once
		wr(6'h10, 32'h0000_0200);
		send_req_i <= 1'b1;
		exp_tx(`SBL_STX);
		send_req_i <= 1'b0;
		peer.put(`SBL_NAK, 3'h0);
		exp_tx(`SBL_STX);
		exp_tx(`SBL_NAK);
		peer.put(`SBL_ETX, 3'h0);
		exp_tx(`SBL_NAK);
		rd(6'h10, 32'h0000_0207, 32'h0007_03ff);
		complete_run();
	end
endmodule
`default_nettype wire
